// *** rtl/ifr_defs.svh ***
`ifndef IFR_DEFS_SVH
`define IFR_DEFS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define IFR_ADDR_W 6
`define IFR_ADDR_ENABLE 6'h06
`define IFR_ADDR_REQUEST 6'h07
`define IFR_RESET_VALUE 8'h00
`define IFR_READ_NONE 8'h00

// ****************************************************************
// field positions
// ****************************************************************
`define IFR_BIT_POLARITY 7
`define IFR_BIT_RESERVED 6
`define IFR_BIT_COUNTDOWN 5
`define IFR_BIT_TRANSFER 4
`define IFR_BIT_RECEIVE 3
`define IFR_BIT_COMMAND 2
`define IFR_BIT_BUF_HIGH 1
`define IFR_BIT_BUF_LOW 0
`define IFR_STORE_MASK 8'h3F

// ****************************************************************
// command and timer codes
// ****************************************************************
`define IFR_CMD_W 6
`define IFR_CMD_IDLE 6'h00
`define IFR_TIMER_W 8
`define IFR_TIMER_LAST 8'h01

`endif

// *** rtl/ifr_pkg.sv ***
`include "ifr_defs.svh"

package ifr_pkg;

  // host side register access, one request per cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`IFR_ADDR_W-1:0] addr;
    logic [7:0] data;
  } ifr_bus_req_t;

  // hardware events; done, tick, unknown and start are one-cycle pulses, countdown value, command and buffer levels are held values
  typedef struct packed {
    logic timer_tick;
    logic [`IFR_TIMER_W-1:0] countdown_value;
    logic transmit_done;
    logic checksum_done;
    logic eeprom_done;
    logic receive_end;
    logic cmd_unknown;
    logic cmd_host_start;
    logic [`IFR_CMD_W-1:0] command;
    logic buffer_high_level;
    logic buffer_low_level;
  } ifr_events_t;

  typedef struct packed {
    logic [`IFR_CMD_W-1:0] cmd_prev;
    logic buf_high_prev;
    logic buf_low_prev;
    logic irq;
    logic [7:0] rd_data;
  } ifr_top_state_t;

endpackage

// *** rtl/ifr_polreg.sv ***
`timescale 1ns/1ps
`include "ifr_defs.svh"

module ifr_polreg #(
  parameter int W = 8,
  parameter logic [7:0] MASK = `IFR_STORE_MASK
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic [W-1:0] set_i,
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] value;
  } ifr_pstate_t;

  ifr_pstate_t state;
  ifr_pstate_t next_state;
  logic [W-1:0] mask;
  logic [W-1:0] marked;

  assign mask = MASK[W-1:0];
  assign marked = wdata_i & mask;

  // ****************************************************************
  // polarity write, hardware set applied last so it wins
  // ****************************************************************
  always_comb begin
    next_state = state;
    if (wr_i) begin
      if (wdata_i[`IFR_BIT_POLARITY]) begin
        next_state.value = state.value | marked;
      end else begin
        next_state.value = state.value & ~marked;
      end
    end
    next_state.value = (next_state.value | set_i) & mask;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state.value <= W'(`IFR_RESET_VALUE);
    end else begin
      state <= next_state;
    end
  end

  assign q_o = state.value;

endmodule

// *** rtl/ifr_top.sv ***
`timescale 1ns/1ps
`include "ifr_defs.svh"

// Overview of operation
// - request flag write: bit 7 one sets marked flags, zero clears them
// - countdown expired flag set when timer decrements its value to zero
// - transfer done flag set when send-and-receive finished transmitting
// - transfer done flag set when checksum command processed all input
// - transfer done flag set when eeprom programming finished all data
// - command finished flag set when command changes from other to idle
// - command finished flag set when an unrecognised command starts
// - host starting the idle command does not set command finished
// - buffer high flag set when buffer high level bit becomes set
// - buffer low flag set when buffer low level bit becomes set
// - flags hold until host clears them; level loss does not clear
// - request flag register sits at 07h and resets to 00h
// - each flag drives the interrupt output only with its enable set
// - enable bits change only through a polarity write at 06h
module ifr_top
  import ifr_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter logic [`IFR_CMD_W-1:0] CMD_IDLE = `IFR_CMD_IDLE
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire ifr_bus_req_t BUS_I,
  input wire ifr_events_t EVENTS_I,
  output logic [DATA_W-1:0] RD_DATA_O,
  output logic [DATA_W-1:0] FLAGS_O,
  output logic [DATA_W-1:0] ENABLES_O,
  output logic IRQ_O
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic ifr_rise(input logic prev, input logic now);
    ifr_rise = now & ~prev;
  endfunction

  function automatic logic ifr_hit(input ifr_bus_req_t req,
                                   input logic [`IFR_ADDR_W-1:0] addr);
    ifr_hit = (req.addr == addr);
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  ifr_top_state_t state;
  ifr_top_state_t next_state;

  logic [DATA_W-1:0] flag_q;
  logic [DATA_W-1:0] enable_q;
  logic [DATA_W-1:0] flag_set;
  logic [DATA_W-1:0] no_set;
  logic wr_flags;
  logic wr_enable;
  logic rd_flags;
  logic rd_enable;
  logic countdown_hit;
  logic transfer_hit;
  logic command_hit;
  logic went_idle;

  // ****************************************************************
  // host access decode
  // ****************************************************************
  assign wr_flags = BUS_I.wr & ifr_hit(BUS_I, `IFR_ADDR_REQUEST);
  assign wr_enable = BUS_I.wr & ifr_hit(BUS_I, `IFR_ADDR_ENABLE);
  assign rd_flags = BUS_I.rd & ifr_hit(BUS_I, `IFR_ADDR_REQUEST);
  assign rd_enable = BUS_I.rd & ifr_hit(BUS_I, `IFR_ADDR_ENABLE);

  // ****************************************************************
  // event detection
  // ****************************************************************
  // the tick carries the value before the decrement, so the last step is 1 -> 0
  assign countdown_hit = EVENTS_I.timer_tick &
                         (EVENTS_I.countdown_value == `IFR_TIMER_LAST);

  assign transfer_hit = EVENTS_I.transmit_done |
                        EVENTS_I.checksum_done |
                        EVENTS_I.eeprom_done;

  // a host write of idle also moves the command to idle, hence the qualifier
  assign went_idle = (state.cmd_prev != CMD_IDLE) &
                     (EVENTS_I.command == CMD_IDLE);
  assign command_hit = (went_idle & ~EVENTS_I.cmd_host_start) |
                       EVENTS_I.cmd_unknown;

  always_comb begin
    flag_set = '0;
    flag_set[`IFR_BIT_COUNTDOWN] = countdown_hit;
    flag_set[`IFR_BIT_TRANSFER] = transfer_hit;
    flag_set[`IFR_BIT_RECEIVE] = EVENTS_I.receive_end;
    flag_set[`IFR_BIT_COMMAND] = command_hit;
    flag_set[`IFR_BIT_BUF_HIGH] = ifr_rise(state.buf_high_prev,
                                           EVENTS_I.buffer_high_level);
    flag_set[`IFR_BIT_BUF_LOW] = ifr_rise(state.buf_low_prev,
                                          EVENTS_I.buffer_low_level);
  end

  assign no_set = '0;

  // ****************************************************************
  // request flag register
  // ****************************************************************
  ifr_polreg #(
    .W(DATA_W),
    .MASK(`IFR_STORE_MASK)
  ) u_flags (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .wr_i(wr_flags),
    .wdata_i(BUS_I.data[DATA_W-1:0]),
    .set_i(flag_set),
    .q_o(flag_q)
  );

  // ****************************************************************
  // enable register
  // ****************************************************************
  // software only; hardware never sets an enable
  ifr_polreg #(
    .W(DATA_W),
    .MASK(`IFR_STORE_MASK)
  ) u_enable (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .wr_i(wr_enable),
    .wdata_i(BUS_I.data[DATA_W-1:0]),
    .set_i(no_set),
    .q_o(enable_q)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_state = state;
    next_state.cmd_prev = EVENTS_I.command;
    next_state.buf_high_prev = EVENTS_I.buffer_high_level;
    next_state.buf_low_prev = EVENTS_I.buffer_low_level;
    next_state.irq = |(flag_q & enable_q);
    if (rd_flags) begin
      // stored bits only, so bits 7 and 6 read zero
      next_state.rd_data = flag_q & `IFR_STORE_MASK;
    end else if (rd_enable) begin
      next_state.rd_data = enable_q & `IFR_STORE_MASK;
    end else if (BUS_I.rd) begin
      next_state.rd_data = `IFR_READ_NONE;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state.cmd_prev <= CMD_IDLE;
      state.buf_high_prev <= 1'h0;
      state.buf_low_prev <= 1'h0;
      state.irq <= 1'h0;
      state.rd_data <= `IFR_RESET_VALUE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign RD_DATA_O = state.rd_data;
  assign FLAGS_O = flag_q;
  assign ENABLES_O = enable_q;
  assign IRQ_O = state.irq;

endmodule

// *** verif/ifr_chk.sv ***
`timescale 1ns/1ps
`include "ifr_defs.svh"
module ifr_chk
  import ifr_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire ifr_bus_req_t BUS_I,
  input wire ifr_events_t EVENTS_I,
  input wire logic [7:0] RD_DATA_O,
  input wire logic [7:0] FLAGS_O,
  input wire logic [7:0] ENABLES_O,
  input wire logic IRQ_O
);
  // ****
  // flag rules
  // ****
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  wire logic wq = BUS_I.wr && BUS_I.addr == `IFR_ADDR_REQUEST;
  wire ifr_events_t e = EVENTS_I;
  flag_write_a: assert property (
    wq && BUS_I.data[7] |=> (FLAGS_O[5:0] & $past(BUS_I.data[5:0])) == $past(BUS_I.data[5:0]))
    else $error("set write lost");
  tmr_set_a: assert property (
    e.timer_tick && e.countdown_value == `IFR_TIMER_LAST |=> FLAGS_O[5]) else $error("timer flag");
  tx_set_a: assert property (
    e.transmit_done || e.checksum_done || e.eeprom_done |=> FLAGS_O[4]) else $error("tx flag");
  rx_set_a: assert property (e.receive_end |=> FLAGS_O[3]) else $error("rx flag");
  cmd_idle_a: assert property (
    !$past(RST_I) && $past(e.command) != 0 && e.command == 0 && !e.cmd_host_start |=> FLAGS_O[2])
    else $error("idle flag");
  cmd_unk_a: assert property (e.cmd_unknown |=> FLAGS_O[2]) else $error("unknown cmd");
  buf_high_a: assert property (
    $rose(e.buffer_high_level) |=> FLAGS_O[1]) else $error("high flag");
  buf_low_a: assert property (
    $rose(e.buffer_low_level) |=> FLAGS_O[0]) else $error("low flag");
  flag_hold_a: assert property (
    !$past(RST_I) && |($past(FLAGS_O[5:0]) & ~FLAGS_O[5:0]) |-> $past(wq) && !$past(BUS_I.data[7]))
    else $error("flag cleared alone");
  irq_gate_a: assert property (
    !$past(RST_I) |-> IRQ_O == |($past(FLAGS_O) & $past(ENABLES_O))) else $error("irq wrong");
  enable_write_a: assert property (
    BUS_I.wr && BUS_I.addr == `IFR_ADDR_ENABLE |=> ENABLES_O[5:0] == ($past(BUS_I.data[7])
      ? ($past(ENABLES_O[5:0]) | $past(BUS_I.data[5:0]))
      : ($past(ENABLES_O[5:0]) & ~$past(BUS_I.data[5:0]))))
    else $error("enable write");
  enable_hold_a: assert property (
    !(BUS_I.wr && BUS_I.addr == `IFR_ADDR_ENABLE) |=> $stable(ENABLES_O)) else $error("enable moved");
  rsv_zero_a: assert property (
    FLAGS_O[7:6] == 2'h0 && ENABLES_O[7:6] == 2'h0) else $error("reserved bits set");
  read_flag_a: assert property (
    BUS_I.rd && BUS_I.addr == `IFR_ADDR_REQUEST |=> RD_DATA_O == $past(FLAGS_O))
    else $error("read data");
endmodule

bind ifr_top ifr_chk u_chk (.CLK_I(CLK_I), .RST_I(RST_I), .BUS_I(BUS_I), .EVENTS_I(EVENTS_I),
  .RD_DATA_O(RD_DATA_O), .FLAGS_O(FLAGS_O), .ENABLES_O(ENABLES_O), .IRQ_O(IRQ_O));

// *** verif/ifr_host.sv ***
`timescale 1ns/1ps
module ifr_host
  import ifr_pkg::*;
(
  input wire logic clk_i,
  output ifr_bus_req_t bus_o
);
  initial bus_o = '0;
  // ****
  // one access, strobe held over the taking edge
  // ****
  task automatic put(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    bus_o = '{w, !w, a, d};
    @(posedge clk_i);
    #1;
    bus_o = '{1'b0, 1'b0, ~a, ~d};
  endtask
endmodule

// *** verif/tb_ifr_top.sv ***
`timescale 1ns/1ps
`include "ifr_defs.svh"
module tb_ifr_top
  import ifr_pkg::*;
;
  logic CLK_I = 0;
  logic RST_I = 1;
  ifr_bus_req_t bus;
  ifr_events_t ev = '0;
  logic [7:0] rdo, flo, eno;
  logic irq;
  logic [31:0] q = 32'h7A9C9A21;
  int bad_count = 0;
  int check_count = 0;
  int mf, me, mr, mi, nf, ph, pl, pc;
  ifr_top uut (.CLK_I(CLK_I), .RST_I(RST_I), .BUS_I(bus), .EVENTS_I(ev), .RD_DATA_O(rdo),
    .FLAGS_O(flo), .ENABLES_O(eno), .IRQ_O(irq));
  ifr_host host (.clk_i(CLK_I), .bus_o(bus));
  // ****
  // helpers
  // ****
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int pw(input int v, input logic [7:0] d);
    return d[7] ? (v | int'(d[5:0])) : (v & ~int'(d[5:0]));
  endfunction
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] x);
    check_count++;
    if (s !== x) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ****
  // reference model, compared every cycle
  // ****
  always @(posedge CLK_I) begin
    if (RST_I) begin
      {mf, me, mr, mi, ph, pl, pc} = '0;
    end else begin
      check("flags", flo, mf[7:0]);
      check("enables", eno, me[7:0]);
      check("irq", {7'h00, irq}, mi[7:0]);
      check("read", rdo, mr[7:0]);
      mi = int'((mf & me) != 0);
      if (bus.rd) begin
        mr = bus.addr == `IFR_ADDR_REQUEST ? mf : bus.addr == `IFR_ADDR_ENABLE ? me : 0;
      end
      nf = mf;
      if (bus.wr && bus.addr == `IFR_ADDR_REQUEST) nf = pw(nf, bus.data);
      if (bus.wr && bus.addr == `IFR_ADDR_ENABLE) me = pw(me, bus.data);
      nf |= {ev.timer_tick && ev.countdown_value == 8'h01,
        ev.transmit_done | ev.checksum_done | ev.eeprom_done, ev.receive_end,
        ev.cmd_unknown | (pc != 0 && ev.command == 6'h00 && !ev.cmd_host_start),
        ev.buffer_high_level & (ph == 0), ev.buffer_low_level & (pl == 0)};
      mf = nf;
      ph = int'(ev.buffer_high_level);
      pl = int'(ev.buffer_low_level);
      pc = int'(ev.command);
    end
  end
  // ****
  // stimulus
  // ****
  initial begin
    forever #25 CLK_I = ~CLK_I;
  end
  // random events; set-wins against host clears is exercised freely
  always @(posedge CLK_I) begin
    q <= nx(q);
    ev <= #1 RST_I ? '0 : ifr_events_t'{q[0], q[1] ? 8'h01 : q[15:8], q[2] & q[3], q[3] & q[4],
      q[4] & q[5],
      q[5] & q[6], q[6] & q[7], q[16], q[17] ? 6'h00 : q[23:18], q[24], q[25]};
  end
  initial begin
    repeat (12) @(posedge CLK_I);
    #1;
    RST_I = 0;
    for (int i = 0; i < 400; i++) begin
      if (i == 200) begin
        // second reset in mid-run: every register must come back at zero
        RST_I = 1;
        repeat (3) @(posedge CLK_I);
        #1;
        RST_I = 0;
      end
      host.put(q[26], q[27] ? `IFR_ADDR_REQUEST : (q[28] ? `IFR_ADDR_ENABLE : 6'h05),
        q[31:24] ^ q[7:0]);
    end
    finish_test();
  end
endmodule
